/* File: rtl/ambient_pkg.sv */
// Purpose: Shared constants and types for the ambient level backlight select block
// Assumes: 10 MHz mclk; sensor reading in 0.5 uA steps
// Notes:   Register offsets are byte addresses on the device register port
package ambient_pkg;

   // Register offsets
   localparam logic [7:0] FADE_OFS         = 8'h04;
   localparam logic [7:0] LEVEL1_PEAK_OFS  = 8'h05;
   localparam logic [7:0] LEVEL1_LOW_OFS   = 8'h06;
   localparam logic [7:0] LEVEL2_PEAK_OFS  = 8'h07;
   localparam logic [7:0] LEVEL2_LOW_OFS   = 8'h08;
   localparam logic [7:0] LEVEL3_PEAK_OFS  = 8'h09;
   localparam logic [7:0] LEVEL3_LOW_OFS   = 8'h0A;
   localparam logic [7:0] PRESENT_CODE_OFS = 8'h0B;
   localparam logic [7:0] COMPARE_CFG_OFS  = 8'h0C;
   localparam logic [7:0] OFFICE_TRIP_OFS  = 8'h0D;
   localparam logic [7:0] OFFICE_HYS_OFS   = 8'h0E;
   localparam logic [7:0] DARK_TRIP_OFS    = 8'h0F;
   localparam logic [7:0] DARK_HYS_OFS     = 8'h10;

   // Field positions in the comparator configuration register
   localparam int FILTER_MSB  = 7;
   localparam int FILTER_LSB  = 5;
   localparam int FORCE_BIT   = 4;
   localparam int DARK_EN_BIT = 1;
   localparam int OFF_EN_BIT  = 0;

   // Values after reset
   localparam logic [6:0] CODE_RESET = 7'h00;
   localparam logic [7:0] FADE_RESET = 8'h00;
   localparam logic [2:0] SENSOR_FILTER_TIME_RESET = 3'h0;

   // Timing
   localparam int unsigned CLK_PERIOD_NS      = 100;
   localparam int unsigned FILTER_BASE_NS     = 80000000;
   localparam int unsigned FILTER_BASE_CYCLES = FILTER_BASE_NS / CLK_PERIOD_NS;
   localparam int          CONVERT_CYCLES     = 4;

   // Sensor scaling: office codes are 4 uA, sensor and dark codes 0.5 uA
   localparam int unsigned      OFFICE_STEP_NA  = 4000;
   localparam int unsigned      SENSOR_STEP_NA  = 500;
   localparam logic [10:0]      OFFICE_RATIO    = 11'(OFFICE_STEP_NA / SENSOR_STEP_NA);

   typedef enum logic [1:0] {
      LEVEL_DAYLIGHT = 2'b00,
      LEVEL_OFFICE   = 2'b01,
      LEVEL_DARK     = 2'b10
   } level_type;

   typedef enum logic {
      SEQ_IDLE    = 1'b0,
      SEQ_CONVERT = 1'b1
   } seq_state_type;

   // Mirrors the comparator configuration register bit for bit
   typedef struct packed {
      logic [2:0] filter_time;
      logic       force_read;
      logic       dark_level_flag;
      logic       office_level_flag;
      logic       dark_comparator_enable;
      logic       office_comparator_enable;
   } compare_cfg_type;

endpackage

/* File: rtl/conversion_sequencer.sv */
// Purpose: Paces light sensor conversions by filter period and by forced request
// Assumes: force_read stays high until forced_done_q has been seen
// Notes:   A period end that falls inside a running conversion is dropped
`timescale 1ns/1ps
`default_nettype none
module conversion_sequencer #(
   parameter int unsigned FILTER_BASE_CYCLES = ambient_pkg::FILTER_BASE_CYCLES
) (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rstn,
   input  wire logic       clk_en,
   // Control
   input  wire logic [2:0] filter_time,
   input  wire logic       periodic_en,
   input  wire logic       force_read,
   // Results
   output logic            conv_done_q,
   output logic            forced_done_q
);
   localparam int CONV_LEN = ambient_pkg::CONVERT_CYCLES;

   ambient_pkg::seq_state_type state_q;
   logic [31:0]                period_cnt_q;
   logic [31:0]                period_end_cnt;
   logic [2:0]                 conv_cnt_q;
   logic                       forced_q;
   logic                       period_end;
   logic                       force_start;

   assign period_end_cnt = (32'(FILTER_BASE_CYCLES) << filter_time) - 32'h1;
   assign period_end     = periodic_en && (period_cnt_q >= period_end_cnt);
   // Block a restart while the finished force bit is still being cleared
   assign force_start    = force_read && !forced_done_q;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         period_cnt_q <= 32'h0;
      end else if (clk_en) begin
         if (!periodic_en || period_end) begin
            period_cnt_q <= 32'h0;
         end else begin
            period_cnt_q <= period_cnt_q + 32'h1;
         end
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state_q       <= ambient_pkg::SEQ_IDLE;
         conv_cnt_q    <= 3'h0;
         forced_q      <= 1'b0;
         conv_done_q   <= 1'b0;
         forced_done_q <= 1'b0;
      end else if (clk_en) begin
         conv_done_q   <= 1'b0;
         forced_done_q <= 1'b0;
         unique case (state_q)
            ambient_pkg::SEQ_IDLE: begin
               if (period_end || force_start) begin
                  state_q    <= ambient_pkg::SEQ_CONVERT;
                  conv_cnt_q <= 3'h0;
                  forced_q   <= force_start;
               end
            end
            ambient_pkg::SEQ_CONVERT: begin
               conv_cnt_q <= conv_cnt_q + 3'h1;
               if (conv_cnt_q == 3'(CONV_LEN - 1)) begin
                  state_q       <= ambient_pkg::SEQ_IDLE;
                  conv_done_q   <= 1'b1;
                  forced_done_q <= forced_q;
               end
            end
         endcase
      end
   end

   sequence conv_start_s;
      $rose(state_q == ambient_pkg::SEQ_CONVERT);
   endsequence

   property conv_len_p;
      @(posedge mclk) disable iff (!rstn || !clk_en)
         conv_start_s |-> ##CONV_LEN conv_done_q;
   endproperty

   conv_length_a: assert property (conv_len_p)
      else $error("conversion did not finish in the fixed time");

   period_wrap_a: assert property (
      @(posedge mclk) disable iff (!rstn || !clk_en)
         period_end |=> (period_cnt_q == 32'h0))
      else $error("filter period counter did not restart");

endmodule
`default_nettype wire

/* File: rtl/ambient_level_backlight_select.sv */
// Purpose: Per ambient level backlight codes and ambient light comparator control
// Assumes: Register port is the byte side of the serial interface, one access a cycle
// Notes:   Fading is not applied here; the present code is the selected target
// Functional notes
// - Full brightness uses peak code of level
// - Dimmed uses low code; bit 7 unused
// - Read-only present code; writes ignored
// - Filter time bits 7-5, doubling from 0.08 s
// - Force-read bit starts exactly one conversion
// - Sequencer clears force-read when conversion finished
// - Dark flag bit 3 reports dark level
// - Office flag bit 2 reports office level
// - Bit 1 enables dark comparator
// - Bit 0 enables office comparator
// - Office flag sets below office trip
// - Office trip code is 4 uA steps
// - Office flag clears above trip plus hysteresis
// - Dark flag sets below dark trip, 0.5 uA
// - Fade register holds fade-out and fade-in times
`timescale 1ns/1ps
`default_nettype none
module ambient_level_backlight_select #(
   parameter int unsigned FILTER_BASE_CYCLES = ambient_pkg::FILTER_BASE_CYCLES
) (
   // Clock and reset
   input  wire logic                  mclk,
   input  wire logic                  rstn,
   input  wire logic                  clk_en,
   // Register port
   input  wire logic [7:0]            reg_addr,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   input  wire logic [7:0]            reg_wdata,
   output logic [7:0]                 reg_rdata_q,
   // Light sensor reading, 0.5 uA a step
   input  wire logic [10:0]           sensor_level,
   // Backlight control from the rest of the device
   input  wire logic                  automatic_adjust_enable,
   input  wire logic                  backlight_on_request,
   input  wire logic                  dim_request,
   // Backlight result
   output logic [6:0]                 present_current_code_q,
   output ambient_pkg::level_type     ambient_level_select_q,
   output logic [7:0]                 fade_time_config_q
);
   localparam int FORCE_WAIT_MAX = 12;

   ambient_pkg::compare_cfg_type cfg_q;
   ambient_pkg::level_type       level_d;
   logic [6:0]                   peak_q [0:2];
   logic [6:0]                   low_q  [0:2];
   logic [6:0]                   office_trip_q;
   logic [6:0]                   office_hys_q;
   logic [6:0]                   dark_trip_q;
   logic [6:0]                   dark_hys_q;
   logic [6:0]                   code_d;
   logic                         conv_done;
   logic                         forced_done;
   logic                         any_enable;
   logic                         cfg_wr;
   logic                         office_next;
   logic                         dark_next;
   logic [1:0]                   level_idx;

   function automatic logic [10:0] office_scale(input logic [6:0] code);
      office_scale = 11'(code) * ambient_pkg::OFFICE_RATIO;
   endfunction

   function automatic logic [10:0] dark_scale(input logic [6:0] code);
      dark_scale = {4'h0, code};
   endfunction

   // Comparator with hysteresis band between trip and trip plus hysteresis
   function automatic logic hyst_flag(input logic        flag,
                                      input logic [10:0] level,
                                      input logic [10:0] trip,
                                      input logic [10:0] hys);
      logic [11:0] rise;
      rise = {1'b0, trip} + {1'b0, hys};
      if (level < trip) begin
         hyst_flag = 1'b1;
      end else if ({1'b0, level} > rise) begin
         hyst_flag = 1'b0;
      end else begin
         hyst_flag = flag;
      end
   endfunction

   function automatic logic is_write(input logic [7:0] addr, input logic [7:0] ofs,
                                     input logic wr);
      is_write = wr && (addr == ofs);
   endfunction

   assign cfg_wr     = is_write(reg_addr, ambient_pkg::COMPARE_CFG_OFS, reg_wr);
   assign any_enable = cfg_q.dark_comparator_enable || cfg_q.office_comparator_enable;

   conversion_sequencer #(
      .FILTER_BASE_CYCLES (FILTER_BASE_CYCLES)
   ) sequencer (
      .mclk          (mclk),
      .rstn          (rstn),
      .clk_en        (clk_en),
      .filter_time   (cfg_q.filter_time),
      .periodic_en   (any_enable),
      .force_read    (cfg_q.force_read),
      .conv_done_q   (conv_done),
      .forced_done_q (forced_done)
   );

   assign office_next = hyst_flag(cfg_q.office_level_flag, sensor_level,
                                  office_scale(office_trip_q), office_scale(office_hys_q));
   assign dark_next   = hyst_flag(cfg_q.dark_level_flag, sensor_level,
                                  dark_scale(dark_trip_q), dark_scale(dark_hys_q));

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         fade_time_config_q <= ambient_pkg::FADE_RESET;
      end else if (clk_en && is_write(reg_addr, ambient_pkg::FADE_OFS, reg_wr)) begin
         fade_time_config_q <= reg_wdata;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < 3; i++) begin
            peak_q[i] <= ambient_pkg::CODE_RESET;
            low_q[i]  <= ambient_pkg::CODE_RESET;
         end
      end else if (clk_en && reg_wr) begin
         unique case (reg_addr)
            ambient_pkg::LEVEL1_PEAK_OFS: peak_q[0] <= reg_wdata[6:0];
            ambient_pkg::LEVEL1_LOW_OFS:  low_q[0]  <= reg_wdata[6:0];
            ambient_pkg::LEVEL2_PEAK_OFS: peak_q[1] <= reg_wdata[6:0];
            ambient_pkg::LEVEL2_LOW_OFS:  low_q[1]  <= reg_wdata[6:0];
            ambient_pkg::LEVEL3_PEAK_OFS: peak_q[2] <= reg_wdata[6:0];
            ambient_pkg::LEVEL3_LOW_OFS:  low_q[2]  <= reg_wdata[6:0];
            default: begin
            end
         endcase
      end
   end

   // Trip and hysteresis codes
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         office_trip_q <= ambient_pkg::CODE_RESET;
         office_hys_q  <= ambient_pkg::CODE_RESET;
         dark_trip_q   <= ambient_pkg::CODE_RESET;
         dark_hys_q    <= ambient_pkg::CODE_RESET;
      end else if (clk_en && reg_wr) begin
         unique case (reg_addr)
            ambient_pkg::OFFICE_TRIP_OFS: office_trip_q <= reg_wdata[6:0];
            ambient_pkg::OFFICE_HYS_OFS:  office_hys_q  <= reg_wdata[6:0];
            ambient_pkg::DARK_TRIP_OFS:   dark_trip_q   <= reg_wdata[6:0];
            ambient_pkg::DARK_HYS_OFS:    dark_hys_q    <= reg_wdata[6:0];
            default: begin
            end
         endcase
      end
   end

   // Comparator configuration, force request and flags
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cfg_q <= '0;
         cfg_q.filter_time <= ambient_pkg::SENSOR_FILTER_TIME_RESET;
      end else if (clk_en) begin
         if (cfg_wr) begin
            cfg_q.filter_time <= reg_wdata[ambient_pkg::FILTER_MSB:ambient_pkg::FILTER_LSB];
            cfg_q.dark_comparator_enable   <= reg_wdata[ambient_pkg::DARK_EN_BIT];
            cfg_q.office_comparator_enable <= reg_wdata[ambient_pkg::OFF_EN_BIT];
         end
         // sequencer clears force; a new write wins
         if (cfg_wr && reg_wdata[ambient_pkg::FORCE_BIT]) begin
            cfg_q.force_read <= 1'b1;
         end else if (forced_done) begin
            cfg_q.force_read <= 1'b0;
         end
         if (!cfg_q.dark_comparator_enable) begin
            cfg_q.dark_level_flag <= 1'b0;
         end else if (conv_done) begin
            cfg_q.dark_level_flag <= dark_next;
         end
         if (!cfg_q.office_comparator_enable) begin
            cfg_q.office_level_flag <= 1'b0;
         end else if (conv_done) begin
            cfg_q.office_level_flag <= office_next;
         end
      end
   end

   // without automatic adjust the daylight codes stay in use
   always_comb begin
      level_d = ambient_pkg::LEVEL_DAYLIGHT;
      if (automatic_adjust_enable) begin
         if (cfg_q.dark_level_flag) begin
            level_d = ambient_pkg::LEVEL_DARK;
         end else if (cfg_q.office_level_flag) begin
            level_d = ambient_pkg::LEVEL_OFFICE;
         end
      end
   end

   assign level_idx = level_d;

   always_comb begin
      code_d = ambient_pkg::CODE_RESET;
      if (backlight_on_request) begin
         code_d = dim_request ? low_q[level_idx] : peak_q[level_idx];
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         present_current_code_q <= ambient_pkg::CODE_RESET;
         ambient_level_select_q <= ambient_pkg::LEVEL_DAYLIGHT;
      end else if (clk_en) begin
         present_current_code_q <= code_d;
         ambient_level_select_q <= level_d;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata_q <= 8'h00;
      end else if (clk_en && reg_rd) begin
         unique case (reg_addr)
            ambient_pkg::FADE_OFS:         reg_rdata_q <= fade_time_config_q;
            ambient_pkg::LEVEL1_PEAK_OFS:  reg_rdata_q <= {1'b0, peak_q[0]};
            ambient_pkg::LEVEL1_LOW_OFS:   reg_rdata_q <= {1'b0, low_q[0]};
            ambient_pkg::LEVEL2_PEAK_OFS:  reg_rdata_q <= {1'b0, peak_q[1]};
            ambient_pkg::LEVEL2_LOW_OFS:   reg_rdata_q <= {1'b0, low_q[1]};
            ambient_pkg::LEVEL3_PEAK_OFS:  reg_rdata_q <= {1'b0, peak_q[2]};
            ambient_pkg::LEVEL3_LOW_OFS:   reg_rdata_q <= {1'b0, low_q[2]};
            ambient_pkg::PRESENT_CODE_OFS: reg_rdata_q <= {1'b0, present_current_code_q};
            ambient_pkg::COMPARE_CFG_OFS:  reg_rdata_q <= cfg_q;
            ambient_pkg::OFFICE_TRIP_OFS:  reg_rdata_q <= {1'b0, office_trip_q};
            ambient_pkg::OFFICE_HYS_OFS:   reg_rdata_q <= {1'b0, office_hys_q};
            ambient_pkg::DARK_TRIP_OFS:    reg_rdata_q <= {1'b0, dark_trip_q};
            ambient_pkg::DARK_HYS_OFS:     reg_rdata_q <= {1'b0, dark_hys_q};
            default:                       reg_rdata_q <= 8'h00;
         endcase
      end
   end

   default clocking main_cb @(posedge mclk);
   endclocking
   default disable iff (!rstn || !clk_en);

   peak_select_a: assert property (
      backlight_on_request && !dim_request |=> present_current_code_q == $past(peak_q[level_idx]))
      else $error("peak code not used at full brightness");

   dim_select_a: assert property (
      backlight_on_request && dim_request |=> present_current_code_q == $past(low_q[level_idx]))
      else $error("low code not used while dimmed");

   value_read_a: assert property (
      reg_rd && reg_addr == ambient_pkg::PRESENT_CODE_OFS
         |=> reg_rdata_q == {1'b0, $past(present_current_code_q)})
      else $error("present code read back wrong");

   sequence force_set_s;
      !cfg_q.force_read ##1 cfg_q.force_read;
   endsequence

   force_clear_a: assert property (
      force_set_s |-> ##[1:FORCE_WAIT_MAX] !cfg_q.force_read)
      else $error("force bit not cleared after conversion");

   dark_set_a: assert property (
      conv_done && cfg_q.dark_comparator_enable && sensor_level < dark_scale(dark_trip_q)
         |=> cfg_q.dark_level_flag)
      else $error("dark flag not set below trip");

   office_set_a: assert property (
      conv_done && cfg_q.office_comparator_enable
         && sensor_level < office_scale(office_trip_q) |=> cfg_q.office_level_flag)
      else $error("office flag not set below trip");

   office_hold_a: assert property (
      cfg_q.office_level_flag && cfg_q.office_comparator_enable && !cfg_wr
         && !(conv_done && !office_next) |=> cfg_q.office_level_flag)
      else $error("office flag cleared inside hysteresis band");

   dark_disable_a: assert property (
      !cfg_q.dark_comparator_enable |=> !cfg_q.dark_level_flag)
      else $error("dark flag set while comparator disabled");

   office_disable_a: assert property (
      !cfg_q.office_comparator_enable |=> !cfg_q.office_level_flag)
      else $error("office flag set while comparator disabled");

   // A disabled comparator drops its flag one edge later, outside any conversion end
   office_stable_a: assert property (
      !conv_done |=> cfg_q.office_level_flag
         == ($past(cfg_q.office_level_flag) && $past(cfg_q.office_comparator_enable)))
      else $error("office flag changed outside a conversion end");

   dark_stable_a: assert property (
      !conv_done |=> cfg_q.dark_level_flag
         == ($past(cfg_q.dark_level_flag) && $past(cfg_q.dark_comparator_enable)))
      else $error("dark flag changed outside a conversion end");

   level_map_a: assert property (
      automatic_adjust_enable && cfg_q.dark_level_flag
         |=> ambient_level_select_q == ambient_pkg::LEVEL_DARK)
      else $error("dark flag did not select dark level");

   office_map_a: assert property (
      automatic_adjust_enable && cfg_q.office_level_flag && !cfg_q.dark_level_flag
         |=> ambient_level_select_q == ambient_pkg::LEVEL_OFFICE)
      else $error("office flag did not select office level");

   auto_off_a: assert property (
      !automatic_adjust_enable |=> ambient_level_select_q == ambient_pkg::LEVEL_DAYLIGHT)
      else $error("level moved without automatic adjust");

   office_clear_a: assert property (
      conv_done && cfg_q.office_comparator_enable && {1'b0, sensor_level}
         > ({1'b0, office_scale(office_trip_q)} + {1'b0, office_scale(office_hys_q)})
         |=> !cfg_q.office_level_flag)
      else $error("office flag not cleared above the band");

   filter_write_a: assert property (
      cfg_wr |=> cfg_q.filter_time
         == $past(reg_wdata[ambient_pkg::FILTER_MSB:ambient_pkg::FILTER_LSB]))
      else $error("filter time field not written");

   fade_write_a: assert property (
      is_write(reg_addr, ambient_pkg::FADE_OFS, reg_wr)
         |=> fade_time_config_q == $past(reg_wdata))
      else $error("fade register not written");

   present_off_a: assert property (
      !backlight_on_request |=> present_current_code_q == ambient_pkg::CODE_RESET)
      else $error("present code not zero with backlight off");

endmodule
`default_nettype wire

/* File: verification/light_sensor_model.sv */
// Purpose: Light sensor front end feeding the comparators a settled reading
// Assumes: Reading in 0.5 uA steps, changed only on the rising mclk edge
// Notes:   Bench commands the light level; reading follows one edge later
`timescale 1ns/1ps
`default_nettype none
module light_sensor_model (
   // Clock
   input  wire logic        mclk,
   // Commanded light level
   input  wire logic [10:0] light_target,
   // Reading to the block
   output logic [10:0]      sensor_level
);
   // Synchronous level so a conversion never samples a half-changed value
   always_ff @(posedge mclk) begin
      sensor_level <= light_target;
   end
endmodule
`default_nettype wire

/* File: verification/ambient_level_backlight_select_tb.sv */
// Purpose: Self-checking bench for the ambient level backlight select block
// Assumes: Short filter base of 16 cycles
// Notes:   Conversions are forced and polled; periodic runs use wide windows
`timescale 1ns/1ps
`default_nettype none
module ambient_level_backlight_select_tb;
   logic        mclk = 0, rstn = 0, clk_en = 1, reg_wr = 0, reg_rd = 0;
   logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_q, fade_time_config_q, v;
   logic [10:0] light_target = 11'h000, sensor_level;
   logic        automatic_adjust_enable = 0, backlight_on_request = 0, dim_request = 0;
   logic [6:0]  present_current_code_q;
   ambient_pkg::level_type ambient_level_select_q;
   int          fail_count = 0, compares = 0;
   logic [23:0] rows [0:11] = '{24'h04A5A5, 24'h05FF7F, 24'h068101, 24'h072A2A, 24'h081515,
                                24'h09BC3C, 24'h0A3333, 24'h0D9212, 24'h0B5500, 24'h205A00,
                                24'h0E8505, 24'h108303};

   ambient_level_backlight_select #(.FILTER_BASE_CYCLES(16)) ambient_level_backlight_select_inst (
      .mclk(mclk), .rstn(rstn), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
      .sensor_level(sensor_level), .automatic_adjust_enable(automatic_adjust_enable),
      .backlight_on_request(backlight_on_request), .dim_request(dim_request),
      .present_current_code_q(present_current_code_q),
      .ambient_level_select_q(ambient_level_select_q), .fade_time_config_q(fade_time_config_q));
   light_sensor_model light_sensor_model_inst (
      .mclk(mclk), .light_target(light_target), .sensor_level(sensor_level));

   initial begin
      forever #50 mclk = ~mclk;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
         fail_count++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      cyc(1);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1;
      cyc(1);
      reg_wr = 0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      cyc(1);
      reg_addr = a;
      reg_rd = 1;
      cyc(1);
      reg_rd = 0;
      q = reg_rdata_q;
   endtask
   // Force one conversion at a light level, poll for completion, check config readback
   task automatic force_conv(input logic [10:0] lvl, input logic [7:0] cfg, input logic [7:0] e);
      int i;
      light_target = lvl;
      wr(8'h0C, cfg);
      for (i = 0; i < 20; i++) begin
         rd(8'h0C, v);
         if (v[4] === 1'b0) break;
      end
      check(v, e);
   endtask
   task automatic complete_run;
      if (fail_count == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge mclk);
      fail_count++;
      complete_run();
   end

   initial begin
      cyc(12);
      rstn = 1;
      rd(8'h0C, v);
      check(v, 8'h00);
      check({1'b0, present_current_code_q}, 8'h00);
      for (int i = 0; i < 12; i++) begin
         wr(rows[i][23:16], rows[i][15:8]);
         rd(rows[i][23:16], v);
         check(v, rows[i][7:0]);
      end
      check(fade_time_config_q, 8'hA5);
      clk_en = 0;
      wr(8'h05, 8'h11);
      clk_en = 1;
      rd(8'h05, v);
      check(v, 8'h7F);
      backlight_on_request = 1;
      cyc(3);
      check({1'b0, present_current_code_q}, 8'h7F);
      dim_request = 1;
      cyc(3);
      check({1'b0, present_current_code_q}, 8'h01);
      rd(8'h0B, v);
      check(v, 8'h01);
      dim_request = 0;
      // host sets automatic adjust with the enables
      automatic_adjust_enable = 1;
      force_conv(11'd144, 8'h11, 8'h01);
      force_conv(11'd143, 8'h11, 8'h05);
      cyc(3);
      check({6'h00, ambient_level_select_q}, {6'h00, ambient_pkg::LEVEL_OFFICE});
      check({1'b0, present_current_code_q}, 8'h2A);
      wr(8'h0E, 8'h02);
      force_conv(11'd160, 8'h11, 8'h05);
      force_conv(11'd161, 8'h11, 8'h01);
      wr(8'h0F, 8'h0A);
      force_conv(11'd10, 8'h13, 8'h07);
      force_conv(11'd9, 8'h13, 8'h0F);
      cyc(3);
      check({6'h00, ambient_level_select_q}, {6'h00, ambient_pkg::LEVEL_DARK});
      check({1'b0, present_current_code_q}, 8'h3C);
      dim_request = 1;
      cyc(3);
      check({1'b0, present_current_code_q}, 8'h33);
      automatic_adjust_enable = 0;
      cyc(3);
      check({1'b0, present_current_code_q}, 8'h01);
      // Dark hysteresis 3: 13 stays inside the band, 14 leaves it
      force_conv(11'd13, 8'h13, 8'h0F);
      force_conv(11'd14, 8'h13, 8'h07);
      automatic_adjust_enable = 1;
      dim_request = 0;
      wr(8'h0C, 8'h00);
      rd(8'h0C, v);
      check(v, 8'h00);
      cyc(3);
      check({1'b0, present_current_code_q}, 8'h7F);
      // Periodic conversions at filter code 001, 32 cycles a period
      light_target = 11'd100;
      wr(8'h0C, 8'h21);
      // Code 000 would have set the flag by now; code 001 not yet
      cyc(26);
      rd(8'h0C, v);
      check(v, 8'h21);
      cyc(54);
      rd(8'h0C, v);
      check(v, 8'h25);
      light_target = 11'd200;
      cyc(80);
      rd(8'h0C, v);
      check(v, 8'h21);
      backlight_on_request = 0;
      cyc(3);
      check({1'b0, present_current_code_q}, 8'h00);
      rstn = 0;
      cyc(2);
      check({1'b0, present_current_code_q}, 8'h00);
      check(fade_time_config_q, 8'h00);
      complete_run();
   end
endmodule
`default_nettype wire
